// file: logic/lsq_core.sv
`timescale 1ns/1ps
`include "lsq_params.svh"
module lsq_core (
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire lsq_pkg::lsq_in_t   in_pins,
   input  wire logic               diag_select_input,
   input  wire logic               pre_oe_pin,
   input  wire logic               oe_option_fuse,
   input  wire logic               test_array_blown,
   input  wire lsq_pkg::lsq_and_t  and_true_fuse,
   input  wire lsq_pkg::lsq_and_t  and_comp_fuse,
   input  wire lsq_pkg::lsq_or_t   or_set_fuse,
   input  wire lsq_pkg::lsq_or_t   or_rst_fuse,
   input  wire lsq_pkg::lsq_term_t or_c_fuse,
   output logic [`LSQ_OR_W-1:0]    output_register_bits,
   output logic [1:0]              state_bits_lower,
   output logic                    output_oe
);
   import lsq_pkg::*;

   localparam logic [`LSQ_REC_W-1:0] PRE_LOAD = `LSQ_REC_W'(`LSQ_PRE_SETUP_CYC - 1);
   localparam lsq_lit_t C_MASK = lsq_lit_t'(1) << `LSQ_C_BIT;
   // test line sum fuses held as typed constants, since a literal cannot be bit-selected
   localparam lsq_pair_t T48_SET = `LSQ_T48_SET;
   localparam lsq_pair_t T48_RST = `LSQ_T48_RST;
   localparam lsq_pair_t T49_SET = `LSQ_T49_SET;
   localparam lsq_pair_t T49_RST = `LSQ_T49_RST;

   // a term is the AND of every literal whose fuse is intact; blown inputs float high
   function automatic logic prod_term(input lsq_lit_t lit, input lsq_lit_t t,
                                      input lsq_lit_t c);
      prod_term = &((~t | lit) & (~c | ~lit));
   endfunction : prod_term

   // S/R flip-flop step; set and reset together hold the bit
   function automatic logic sr_step(input logic q, input logic s, input logic r);
      sr_step = (s & ~r) | (q & ~(r & ~s));
   endfunction : sr_step

   logic [`LSQ_SYNC_W-1:0] sync_q;
   logic [`LSQ_ST_W-1:0]   state;
   logic [`LSQ_OR_W-1:0]   oreg;
   logic [`LSQ_REC_W-1:0]  rec_cnt;

   lsq_sync #(
      .W (`LSQ_SYNC_W)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({pre_oe_pin, diag_select_input, in_pins}),
      .q    (sync_q)
   );

   // synchronised pins and control decode
   wire lsq_in_t in_s       = sync_q[`LSQ_IN_W-1:0];
   wire logic    diag_s     = sync_q[`LSQ_IN_W];
   wire logic    pre_s      = sync_q[`LSQ_IN_W+1];
   wire logic    preset_act = ~oe_option_fuse & pre_s;
   wire logic    run_en     = ~preset_act & (rec_cnt == '0);

   // first pass ignores the complement feedback literal, which breaks the loop through it
   wire lsq_lit_t  lit1 = {1'b0, state, in_s};
   lsq_term_t      terms1;
   lsq_term_t      uterms;
   logic [`LSQ_ALL_TERMS-1:0] terms;

   // complemented sum term fed back as one more literal
   wire logic     cfb = ~|(terms1 & or_c_fuse);
   wire lsq_lit_t lit = {cfb, state, in_s};

   genvar gi;
   generate
      for (gi = 0; gi < `LSQ_TERMS; gi++) begin : g_term
         assign terms1[gi] = prod_term(lit1, and_true_fuse[gi] & ~C_MASK,
                                       and_comp_fuse[gi] & ~C_MASK);
         assign uterms[gi] = prod_term(lit, and_true_fuse[gi], and_comp_fuse[gi]);
      end
   endgenerate

   // factory test lines stay live until their fuse is blown
   wire logic t48 = ~test_array_blown & prod_term(lit, `LSQ_T48_TRUE, `LSQ_T48_COMP);
   wire logic t49 = ~test_array_blown & prod_term(lit, `LSQ_T49_TRUE, `LSQ_T49_COMP);
   assign terms = {t49, t48, uterms};

   // set/reset sums; one level of OR whatever the fan-in, so the rate never drops
   lsq_pair_t set_v;
   lsq_pair_t rst_v;
   generate
      for (gi = 0; gi < `LSQ_PAIRS; gi++) begin : g_sum
         assign set_v[gi] = |(uterms & or_set_fuse[gi])
                          | (t48 & T48_SET[gi]) | (t49 & T49_SET[gi]);
         assign rst_v[gi] = |(uterms & or_rst_fuse[gi])
                          | (t48 & T48_RST[gi]) | (t49 & T49_RST[gi]);
      end
   endgenerate

   // next register values, one S/R step per bit
   logic [`LSQ_ST_W-1:0] next_state;
   logic [`LSQ_OR_W-1:0] next_oreg;
   generate
      for (gi = 0; gi < `LSQ_ST_W; gi++) begin : g_st
         assign next_state[gi] = sr_step(state[gi], set_v[gi], rst_v[gi]);
      end
      for (gi = 0; gi < `LSQ_OR_W; gi++) begin : g_or
         assign next_oreg[gi] = sr_step(oreg[gi], set_v[`LSQ_ST_W+gi],
                                        rst_v[`LSQ_ST_W+gi]);
      end
   endgenerate

   // pin view: diagnostics swap in the upper state bits without touching storage
   wire logic [`LSQ_OR_W-1:0] next_q_pins = diag_s ? state[5:2] : oreg;
   wire logic [1:0]           next_p_pins = diag_s ? state[7:6] : state[1:0];
   wire logic                 next_oe     = ~oe_option_fuse | ~pre_s;

   // sequencer registers; preset is taken through the synchroniser, so it lands
   // four edges late but can never glitch a register on a runt pulse
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= `LSQ_ST_ONES;
         oreg  <= `LSQ_OR_ONES;
      end else if (preset_act) begin
         state <= `LSQ_ST_ONES;
         oreg  <= `LSQ_OR_ONES;
      end else if (run_en) begin
         state <= next_state;
         oreg  <= next_oreg;
      end
   end

   // recovery counter: blocks edges after power-up and inside the preset setup time
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rec_cnt <= `LSQ_PWRUP_HOLD;
      end else if (preset_act) begin
         rec_cnt <= PRE_LOAD;
      end else if (rec_cnt != '0) begin
         rec_cnt <= rec_cnt - 1'b1;
      end
   end

   // pin registers; outputs come straight from these flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         output_register_bits <= `LSQ_OR_ONES;
         state_bits_lower     <= `LSQ_P_ONES;
         output_oe            <= 1'b1;
      end else begin
         output_register_bits <= next_q_pins;
         state_bits_lower     <= next_p_pins;
         output_oe            <= next_oe;
      end
   end

   // helper: marks the first edge after reset release
   logic first_cyc;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         first_cyc <= 1'b1;
      end else begin
         first_cyc <= 1'b0;
      end
   end

   sequence pre_release;
      preset_act ##1 !preset_act;
   endsequence

   sequence clean_step;
      run_en && !diag_s;
   endsequence

   diag_view_a: assert property (@(posedge clk) disable iff (!nrst)
      diag_s |=> (output_register_bits == $past(state[5:2]))
                 && (state_bits_lower == $past(state[7:6])))
      else $error("diagnostic view wrong");

   diag_keep_a: assert property (@(posedge clk) disable iff (!nrst)
      (run_en && diag_s) |=> (oreg == $past(next_oreg)) && (state == $past(next_state)))
      else $error("diagnostics disturbed registers");

   pin_normal_a: assert property (@(posedge clk) disable iff (!nrst)
      !diag_s |=> (output_register_bits == $past(oreg))
                  && (state_bits_lower == $past(state[1:0])))
      else $error("normal pin view wrong");

   test_line_a: assert property (@(posedge clk) disable iff (!nrst)
      test_array_blown |-> !terms[`LSQ_T48] && !terms[`LSQ_T49])
      else $error("blown test line still active");

   test_loop_a: assert property (@(posedge clk) disable iff (!nrst)
      (!test_array_blown && run_en && in_s[`LSQ_LOOP_HI:`LSQ_LOOP_LO] == `LSQ_LOOP_ZERO)
      |=> oreg == `LSQ_OR_ONES)
      else $error("test line 48 did not set outputs");

   pwrup_high_a: assert property (@(posedge clk) disable iff (!nrst)
      first_cyc |-> (state == `LSQ_ST_ONES) && (oreg == `LSQ_OR_ONES))
      else $error("power-up preset missing");

   preset_high_a: assert property (@(posedge clk) disable iff (!nrst)
      preset_act [*2] |-> (state == `LSQ_ST_ONES) && (oreg == `LSQ_OR_ONES) && !run_en)
      else $error("preset did not force registers high");

   recover_edge_a: assert property (@(posedge clk) disable iff (!nrst)
      pre_release |-> run_en ##1 (state == $past(next_state)))
      else $error("first edge after preset ignored");

   full_rate_a: assert property (@(posedge clk) disable iff (!nrst)
      clean_step ##1 clean_step |=> (state == $past(next_state)) && (oreg == $past(next_oreg)))
      else $error("sequencer skipped an edge");

   sr_set_a: assert property (@(posedge clk) disable iff (!nrst)
      run_en |=> ((state & $past(set_v[7:0] & ~rst_v[7:0])) == $past(set_v[7:0] & ~rst_v[7:0]))
                 && ((state & $past(rst_v[7:0] & ~set_v[7:0])) == '0))
      else $error("set/reset pair not honoured");

   oe_ctrl_a: assert property (@(posedge clk) disable iff (!nrst)
      oe_option_fuse |=> (output_oe == !$past(pre_s)) && !$past(preset_act))
      else $error("output control option wrong");

endmodule : lsq_core

// file: pkg/lsq_params.svh
`ifndef LSQ_PARAMS_SVH
`define LSQ_PARAMS_SVH

// array geometry
`define LSQ_IN_W        14
`define LSQ_ST_W        8
`define LSQ_OR_W        4
`define LSQ_LIT_W       23
`define LSQ_ST_LO       14
`define LSQ_C_BIT       22
`define LSQ_TERMS       48
`define LSQ_ALL_TERMS   50
`define LSQ_T48         48
`define LSQ_T49         49
`define LSQ_PAIRS       12
`define LSQ_LOOP_LO     10
`define LSQ_LOOP_HI     13
`define LSQ_SYNC_W      16

// register images
`define LSQ_ST_ONES     8'hff
`define LSQ_OR_ONES     4'hf
`define LSQ_P_ONES      2'h3
`define LSQ_LOOP_ONES   4'hf
`define LSQ_LOOP_ZERO   4'h0

// factory test array pattern (terms 48 and 49)
`define LSQ_T48_TRUE    23'h000000
`define LSQ_T48_COMP    23'h003c00
`define LSQ_T48_SET     12'hfff
`define LSQ_T48_RST     12'h000
`define LSQ_T49_TRUE    23'h003c00
`define LSQ_T49_COMP    23'h000000
`define LSQ_T49_SET     12'h000
`define LSQ_T49_RST     12'hfff

// timing
`define LSQ_CLK_NS       10
`define LSQ_PRE_SETUP_NS 8
`define LSQ_PRE_SETUP_CYC ((`LSQ_PRE_SETUP_NS + `LSQ_CLK_NS - 1) / `LSQ_CLK_NS)
`define LSQ_REC_W        2
`define LSQ_PWRUP_HOLD   2'h1

`endif

// file: pkg/lsq_pkg.sv
`include "lsq_params.svh"
package lsq_pkg;
   typedef logic [`LSQ_IN_W-1:0]       lsq_in_t;
   typedef logic [`LSQ_LIT_W-1:0]      lsq_lit_t;
   typedef lsq_lit_t [`LSQ_TERMS-1:0]  lsq_and_t;
   typedef logic [`LSQ_TERMS-1:0]      lsq_term_t;
   typedef lsq_term_t [`LSQ_PAIRS-1:0] lsq_or_t;
   typedef logic [`LSQ_PAIRS-1:0]      lsq_pair_t;
endpackage : lsq_pkg

// file: logic/lsq_sync.sv
`timescale 1ns/1ps
`include "lsq_params.svh"
// three-stage pin synchroniser; a bit changes once stages two and three agree
module lsq_sync #(
   parameter int W = `LSQ_SYNC_W
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] ff1;
   logic [W-1:0] ff2;
   logic [W-1:0] ff3;

   // ff1 feeds ff2 only, so a metastable first stage never reaches logic
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ff1 <= '0;
         ff2 <= '0;
         ff3 <= '0;
         q   <= '0;
      end else begin
         ff1 <= d;
         ff2 <= ff1;
         ff3 <= ff2;
         q   <= (ff2 & ff3) | (q & (ff2 ^ ff3));
      end
   end
endmodule : lsq_sync

// file: testbench/lsq_sys_model.sv
`timescale 1ns/1ps
// far-side system logic: drives the array inputs, loops the q pins back on request
module lsq_sys_model (
   input  wire logic        loop_en,
   input  wire logic        oe,
   input  wire logic [3:0]  q_pins,
   input  wire logic [13:0] base_in,
   output lsq_pkg::lsq_in_t in_pins
);
   import lsq_pkg::*;
   // released pins read back inverted, so a floating loop never passes for data
   wire logic [3:0] loop_val;
   assign loop_val = oe ? q_pins : ~q_pins;
   // loopback lands on the four highest inputs
   assign in_pins  = loop_en ? {loop_val, base_in[9:0]} : base_in;
endmodule : lsq_sys_model

// file: testbench/lsq_core_bench.sv
`timescale 1ns/1ps
module lsq_core_bench;
   import lsq_pkg::*;
   logic clk, nrst, diag, pre, oe_fuse, blown, loop_en;
   lsq_in_t in_pins;
   lsq_and_t and_t, and_c;
   lsq_or_t or_s, or_r;
   lsq_term_t or_c;
   logic [3:0] q;
   logic [1:0] p_lo;
   logic oe;
   int errors, samples_checked, cycles;

   lsq_sys_model lsq_sys_model_inst (.loop_en(loop_en), .oe(oe), .q_pins(q),
      .base_in(14'h0000), .in_pins(in_pins));
   lsq_core lsq_core_inst (.clk(clk), .nrst(nrst), .in_pins(in_pins),
      .diag_select_input(diag), .pre_oe_pin(pre), .oe_option_fuse(oe_fuse),
      .test_array_blown(blown), .and_true_fuse(and_t), .and_comp_fuse(and_c),
      .or_set_fuse(or_s), .or_rst_fuse(or_r), .or_c_fuse(or_c),
      .output_register_bits(q), .state_bits_lower(p_lo), .output_oe(oe));

   // 100 MHz, well above what the sequencer must sustain
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         stop_test();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // bounded wait at falling edges for a pin value
   task automatic wait_pins(input logic [3:0] v, input logic ov, input int lim);
      int n;
      n = 0;
      while ((q !== v || oe !== ov) && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_pins

   task automatic do_reset;
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      check({q, p_lo, 1'b0, oe}, 8'hfd);
      nrst = 1'b1;
   endtask : do_reset

   // unprogrammed part: looped outputs toggle all ones / all zeros
   task automatic test_array;
      wait_pins(4'h0, 1'b1, 20);
      check({2'h0, q, p_lo}, 8'h00);
      wait_pins(4'hf, 1'b1, 20);
      check({2'h0, q, p_lo}, 8'h3f);
   endtask : test_array

   // user pattern: term 0 sets state 2..7, clears state_bits_lower and output_register_bits
   task automatic user_program;
      loop_en = 1'b0;
      blown = 1'b1;
      for (int p = 0; p < 12; p++) begin
         or_s[p][0] = (p >= 2 && p < 8);
         or_r[p][0] = !(p >= 2 && p < 8);
      end
      do_reset();
      wait_pins(4'h0, 1'b1, 15);
      check({2'h0, q, p_lo}, 8'h00);
   endtask : user_program

   task automatic diag_read;
      diag = 1'b1;
      wait_pins(4'hf, 1'b1, 10);
      check({2'h0, q, p_lo}, 8'h3f);
      diag = 1'b0;
      // three sync stages, one to agree, then the pin register: exactly five cycles, so
      // a stored value spoiled while diagnostics ran would still be on the pins here
      repeat (5) @(negedge clk);
      check({2'h0, q, p_lo}, 8'h00);
   endtask : diag_read

   task automatic preset_cycle;
      pre = 1'b1;
      wait_pins(4'hf, 1'b1, 8);
      repeat (5) @(negedge clk);
      check({2'h0, q, p_lo}, 8'h3f);
      pre = 1'b0;
      // release lands on a falling edge; the synchroniser keeps the taken edge well past it
      wait_pins(4'h0, 1'b1, 7);
      check({2'h0, q, p_lo}, 8'h00);
   endtask : preset_cycle

   task automatic oe_mode;
      oe_fuse = 1'b1;
      do_reset();
      wait_pins(4'h0, 1'b1, 15);
      pre = 1'b1;
      wait_pins(4'h0, 1'b0, 8);
      check({q, 3'h0, oe}, 8'h00);
      pre = 1'b0;
      wait_pins(4'h0, 1'b1, 8);
      check({q, 3'h0, oe}, 8'h01);
   endtask : oe_mode

   task automatic stop_test;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   initial begin
      errors = 0;
      samples_checked = 0;
      cycles = 0;
      nrst = 1'b0;
      diag = 1'b0;
      pre = 1'b0;
      oe_fuse = 1'b0;
      blown = 1'b0;
      loop_en = 1'b1;
      and_t = '0;
      and_c = '0;
      or_s = '0;
      or_r = '0;
      or_c = '0;
      do_reset();
      test_array();
      user_program();
      diag_read();
      preset_cycle();
      oe_mode();
      stop_test();
   end
endmodule : lsq_core_bench
